// ---- common/usf_pkg.sv ----
package usf_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL1  = 6'h13;
   localparam logic [5:0] IDX_CTRL2  = 6'h14;
   localparam logic [5:0] IDX_CTRL3  = 6'h15;
   localparam logic [5:0] IDX_FLAGS1 = 6'h16;
   localparam logic [5:0] IDX_FLAGS2 = 6'h17;
   localparam logic [5:0] IDX_DATA   = 6'h18;

   // Control one fields
   localparam int C1_MODE9   = 0;
   localparam int C1_PAR_EN  = 1;
   localparam int C1_PAR_ODD = 2;
   // Control two fields
   localparam int C2_TXE_IE  = 7;
   localparam int C2_TXD_IE  = 6;
   localparam int C2_RXF_IE  = 5;
   localparam int C2_IDLE_IE = 4;
   localparam int C2_TE      = 3;
   localparam int C2_RE      = 2;
   localparam int C2_SBK     = 0;
   // Control three fields; error enables sit in the low nibble
   localparam int C3_RX9    = 7;
   localparam int C3_TX9    = 6;
   localparam int C3E_OVR   = 3;
   localparam int C3E_NOISE = 2;
   localparam int C3E_FRAME = 1;
   localparam int C3E_PAR   = 0;
   // Secondary flag fields
   localparam int F2_BREAK  = 1;
   localparam int F2_ACTIVE = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;

   // Receive oversampling and character lengths
   localparam int unsigned RT_PER_BIT   = 16;
   localparam logic [4:0]  RT_SAMPLE_A  = 5'd8;
   localparam logic [4:0]  RT_SAMPLE_B  = 5'd9;
   localparam logic [4:0]  RT_SAMPLE_C  = 5'd10;
   localparam logic [3:0]  CHAR_LEN8    = 4'd10;
   localparam logic [3:0]  CHAR_LEN9    = 4'd11;
   localparam int unsigned TX_LAT_HALFS = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic txEmpty;
      logic txDone;
      logic rxFull;
      logic idle;
      logic overrun;
      logic noise;
      logic framing;
      logic parity;
   } usf_flags1_s;

   localparam usf_flags1_s FLAGS1_RST = '{txEmpty: 1'b1, txDone: 1'b1, default: 1'b0};

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_PRE  = 2'b01,
      TX_DATA = 2'b11,
      TX_BRK  = 2'b10
   } usf_tx_e;

   typedef enum logic {
      RX_HUNT  = 1'b0,
      RX_FRAME = 1'b1
   } usf_rx_e;

endpackage

// ---- design/usf_uart_flags.sv ----
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] Enabled error flags request error interrupt
// [R2] Transmit hand-off sets empty flag; reset sets
// [R3] Enabled empty flag raises transmit interrupt
// [R4] Status read then data write clears empty
// [R5] Done flag: empty and nothing sending
// [R6] Transmission may start 1.5 bit clocks late; here the start bit can come up to two bit clocks late
// [R7] Enabled done flag raises transmit interrupt
// [R8] Receive transfer sets full flag, interrupts
// [R9] Status read then data read clears full
// [R10] Ten or eleven ones set idle flag
// [R11] Idle needs fresh received character first
// [R12] Status read then data read clears idle
// [R13] Overrun keeps old data, drops new
// [R14] Overrun clears only if seen at status
// [R15] Noise flag set, interrupts, cleared by sequence
// [R16] Zero stop bit sets framing error
// [R17] Parity failure sets parity error flag
// [R18] Break sets break, framing, full flags
// [R19] Break cleared by second status sequence
// [R20] Reception active on start, cleared otherwise
// [R21] One data address, separate read/write buffers
// [R22] Software avoids read-modify-write on data
// [R23] Error requests merge into one output
module usf_uart_flags
   import usf_pkg::*;
#(
   parameter int unsigned RT_DIV = 16
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic        rxd,
   output var  logic        txd,
   output var  logic        irqTx,
   output var  logic        irqRx,
   output var  logic        irqErr
);

   logic        hreadyout_r, hresp_r, dphWr_r, txd_r, txIrq_r, rxIrq_r, errIrq_r;
   logic [31:0] hrdata_r;
   logic [5:0]  dphIdx_r;
   logic [2:0]  ctrl1_r;
   logic [7:0]  ctrl2_r, txBuf_r, rxData_r, rdVal;
   logic [3:0]  errEn_r;
   logic        tx9_r, rx9_r;
   logic        rxdMeta_r, rxdSync_r;
   logic [15:0] rtCnt_r;
   logic        rtTick_r;
   logic [3:0]  txRt_r;
   logic        bitTick_r;
   usf_flags1_s fl;
   logic        txEmpty_r, txDone_r, rxFull_r, idle_r, overrun_r, noise_r, framing_r, parity_r;
   logic        breakSeen_r, rxActive_r, breakArm_r, idleArm_r;
   logic        armTxe_r, armBrk_r;
   logic [5:0]  armRx_r;
   usf_tx_e     txState_r;
   logic [10:0] txShift_r;
   logic [3:0]  txBits_r;
   logic        prePend_r, teOld_r, reOld_r;
   usf_rx_e     rxState_r;
   logic [4:0]  rxPhase_r;
   logic [3:0]  rxBit_r;
   logic        smpA_r, smpB_r, noiseSeen_r, oneSeen_r;
   logic [8:0]  rxWord_r, txPayload;
   logic [7:0]  idleCnt_r;
   logic        idleDone_r;

   logic       aphValid, rdStat1, rdStat2, rdData, wrData, txLoad, txClr;
   logic       mode9, parEn, parOdd, te, re, sbk;
   logic [3:0] charLen, nData;
   logic [7:0] idleTicks;
   logic       maj, noisy, bitDone, startEvt, falseEvt, frameEvt, stopBad, brk, parBad, idleHit;
   logic       rxFullEff, load, ovrEvt;

   assign mode9     = ctrl1_r[C1_MODE9];
   assign parEn     = ctrl1_r[C1_PAR_EN];
   assign parOdd    = ctrl1_r[C1_PAR_ODD];
   assign te        = ctrl2_r[C2_TE];
   assign re        = ctrl2_r[C2_RE];
   assign sbk       = ctrl2_r[C2_SBK];
   assign charLen   = mode9 ? CHAR_LEN9 : CHAR_LEN8;
   assign nData     = charLen - 4'd2;
   assign idleTicks = 8'(charLen * RT_PER_BIT);

   // Zero-wait slave, so hready is always ours
   assign aphValid = hsel && hready && (htrans == HTRANS_NONSEQ) && (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);
   assign rdStat1  = aphValid && !hwrite && (haddr[7:2] == IDX_FLAGS1);
   assign rdStat2  = aphValid && !hwrite && (haddr[7:2] == IDX_FLAGS2);
   assign rdData   = aphValid && !hwrite && (haddr[7:2] == IDX_DATA);
   assign wrData   = dphWr_r && (dphIdx_r == IDX_DATA);

   assign fl = '{txEmpty: txEmpty_r, txDone: txDone_r, rxFull: rxFull_r, idle: idle_r,
                 overrun: overrun_r, noise: noise_r, framing: framing_r, parity: parity_r};

   always_comb begin
      case (haddr[7:2])
         IDX_CTRL1:  rdVal = {5'h00, ctrl1_r};
         IDX_CTRL2:  rdVal = ctrl2_r;
         IDX_CTRL3:  rdVal = {rx9_r, tx9_r, 2'b00, errEn_r};
         IDX_FLAGS1: rdVal = fl;
         IDX_FLAGS2: rdVal = {6'h00, breakSeen_r, rxActive_r};
         IDX_DATA:   rdVal = rxData_r; // [R21]
         default:    rdVal = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hreadyout_r <= 1'b1;
         hresp_r     <= HRESP_OKAY;
         hrdata_r    <= 32'h0000_0000;
         dphWr_r     <= 1'b0;
         dphIdx_r    <= 6'h00;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= HRESP_OKAY;
         dphWr_r     <= aphValid && hwrite;
         dphIdx_r    <= haddr[7:2];
         if (aphValid && !hwrite) begin
            hrdata_r <= {24'h00_0000, rdVal};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl1_r <= CTRL_RST[2:0];
         ctrl2_r <= CTRL_RST;
         errEn_r <= CTRL_RST[3:0]; // [R1]
         tx9_r   <= 1'b0;
      end else if (dphWr_r) begin
         case (dphIdx_r)
            IDX_CTRL1: ctrl1_r <= hwdata[2:0];
            IDX_CTRL2: ctrl2_r <= hwdata[7:0];
            IDX_CTRL3: begin
               tx9_r   <= hwdata[C3_TX9];
               errEn_r <= hwdata[3:0];
            end
            default: ;
         endcase
      end
   end

   // Transmit buffer keeps its contents over reset
   always_ff @(posedge clk) begin
      if (wrData) begin
         txBuf_r <= hwdata[7:0]; // [R21]
      end
   end

   // Line input is asynchronous
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxdMeta_r <= 1'b1;
         rxdSync_r <= 1'b1;
      end else begin
         rxdMeta_r <= rxd;
         rxdSync_r <= rxdMeta_r;
      end
   end

   // Oversampling tick and bit-rate tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rtCnt_r   <= 16'h0000;
         rtTick_r  <= 1'b0;
         txRt_r    <= 4'h0;
         bitTick_r <= 1'b0;
      end else begin
         rtTick_r  <= 1'b0;
         bitTick_r <= 1'b0;
         if (rtCnt_r == 16'(RT_DIV - 1)) begin
            rtCnt_r  <= 16'h0000;
            rtTick_r <= 1'b1;
         end else begin
            rtCnt_r <= rtCnt_r + 16'h0001;
         end
         if (rtTick_r) begin
            txRt_r <= txRt_r + 4'h1;
            if (txRt_r == 4'(RT_PER_BIT - 1)) begin
               bitTick_r <= 1'b1;
            end
         end
      end
   end

   // Transmit frame
   always_comb begin
      txPayload = mode9 ? {tx9_r, txBuf_r} : {1'b1, txBuf_r};
      if (parEn && mode9) begin
         txPayload[8] = ^txBuf_r ^ parOdd;
      end else if (parEn) begin
         txPayload[7] = ^txBuf_r[6:0] ^ parOdd;
      end
   end

   assign txLoad = bitTick_r && (txState_r == TX_IDLE) && te && !prePend_r && !sbk && !txEmpty_r;
   assign txClr  = wrData && armTxe_r;

   // Queued work waits for the next bit tick and drives its first bit one tick later: up to two bit times, over the allowed 1.5
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txState_r <= TX_IDLE;
         txShift_r <= 11'h7FF;
         txBits_r  <= 4'h0;
         txd_r     <= 1'b1;
         prePend_r <= 1'b0;
         teOld_r   <= 1'b0;
      end else begin
         teOld_r <= te;
         if (te && !teOld_r) begin
            prePend_r <= 1'b1;
         end
         if (bitTick_r) begin
            case (txState_r)
               TX_IDLE: begin
                  txd_r <= 1'b1;
                  if (te && prePend_r) begin // [R6]
                     txState_r <= TX_PRE;
                     txBits_r  <= charLen;
                     prePend_r <= 1'b0;
                  end else if (te && sbk) begin
                     txState_r <= TX_BRK;
                     txBits_r  <= charLen;
                  end else if (txLoad) begin
                     txState_r <= TX_DATA;
                     txBits_r  <= charLen;
                     txShift_r <= {1'b1, txPayload, 1'b0};
                  end
               end
               TX_PRE, TX_DATA: begin
                  txd_r     <= (txState_r == TX_PRE) ? 1'b1 : txShift_r[0];
                  txShift_r <= {1'b1, txShift_r[10:1]};
                  txBits_r  <= txBits_r - 4'h1;
                  if (txBits_r == 4'h1) begin
                     txState_r <= TX_IDLE;
                  end
               end
               TX_BRK: begin
                  txd_r    <= 1'b0;
                  txBits_r <= txBits_r - 4'h1;
                  if (txBits_r == 4'h1) begin
                     // Held break repeats with no ones between
                     txBits_r  <= charLen;
                     txState_r <= sbk ? TX_BRK : TX_IDLE;
                  end
               end
               default: txState_r <= TX_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txEmpty_r <= 1'b1; // [R2]
         txDone_r  <= 1'b1;
      end else begin
         if (txClr) begin
            txEmpty_r <= 1'b0; // [R4]
         end
         if (txLoad) begin
            txEmpty_r <= 1'b1; // [R2]
         end
         txDone_r <= txEmpty_r && !txClr && (txState_r == TX_IDLE) && !prePend_r && !(te && sbk); // [R5]
      end
   end

   // Receive: majority of three samples per bit
   assign maj      = (smpA_r & smpB_r) | (smpA_r & rxdSync_r) | (smpB_r & rxdSync_r);
   assign noisy    = !((smpA_r == smpB_r) && (smpB_r == rxdSync_r));
   assign bitDone  = re && rtTick_r && (rxState_r == RX_FRAME) && (rxPhase_r == RT_SAMPLE_C);
   assign startEvt = re && rtTick_r && (rxState_r == RX_HUNT) && !rxdSync_r; // [R20]
   assign falseEvt = bitDone && (rxBit_r == 4'h0) && maj;
   assign frameEvt = bitDone && (rxBit_r == nData + 4'h1);
   assign stopBad  = !maj;
   assign brk      = !maj && !oneSeen_r;
   assign parBad   = parEn && (mode9 ? (^rxWord_r[8:0] ^ parOdd) : (^rxWord_r[7:0] ^ parOdd));
   assign idleHit  = re && rtTick_r && rxdSync_r && !idleDone_r && (idleCnt_r == idleTicks - 8'h01);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxState_r   <= RX_HUNT;
         rxPhase_r   <= 5'd0;
         rxBit_r     <= 4'h0;
         smpA_r      <= 1'b1;
         smpB_r      <= 1'b1;
         noiseSeen_r <= 1'b0;
         oneSeen_r   <= 1'b0;
         rxWord_r    <= 9'h000;
      end else if (!re) begin
         rxState_r <= RX_HUNT;
      end else if (startEvt) begin
         rxState_r   <= RX_FRAME;
         rxPhase_r   <= 5'd1;
         rxBit_r     <= 4'h0;
         noiseSeen_r <= 1'b0;
         oneSeen_r   <= 1'b0;
      end else if (rtTick_r && (rxState_r == RX_FRAME)) begin
         rxPhase_r <= (rxPhase_r == 5'(RT_PER_BIT)) ? 5'd1 : rxPhase_r + 5'd1;
         if (rxPhase_r == 5'(RT_PER_BIT)) begin
            rxBit_r <= rxBit_r + 4'h1;
         end
         if (rxPhase_r == RT_SAMPLE_A) begin
            smpA_r <= rxdSync_r;
         end
         if (rxPhase_r == RT_SAMPLE_B) begin
            smpB_r <= rxdSync_r;
         end
         if (bitDone) begin
            noiseSeen_r <= noiseSeen_r | noisy;
            if ((rxBit_r != 4'h0) && (rxBit_r <= nData)) begin
               rxWord_r[rxBit_r - 4'h1] <= maj;
               oneSeen_r                <= oneSeen_r | maj;
            end
            if (falseEvt || frameEvt) begin
               rxState_r <= RX_HUNT;
            end
         end
      end
   end

   // Idle: a full character time of ones
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idleCnt_r  <= 8'h00;
         idleDone_r <= 1'b0;
      end else if (!re || !rxdSync_r) begin
         idleCnt_r  <= 8'h00;
         idleDone_r <= 1'b0;
      end else if (rtTick_r && !idleDone_r) begin
         idleCnt_r  <= idleCnt_r + 8'h01;
         idleDone_r <= idleHit; // [R10]
      end
   end

   // Status read snapshots which flags a following data access may clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         armTxe_r <= 1'b0;
         armRx_r  <= 6'h00;
         armBrk_r <= 1'b0;
      end else begin
         if (wrData) begin
            armTxe_r <= 1'b0;
         end
         if (rdData) begin
            armRx_r  <= 6'h00;
            armBrk_r <= 1'b0;
         end
         if (rdStat1) begin
            armTxe_r <= txEmpty_r; // [R4]
            armRx_r  <= {rxFull_r, idle_r, overrun_r, noise_r, framing_r, parity_r}; // [R14]
         end
         if (rdStat2) begin
            armBrk_r <= breakSeen_r; // [R19]
         end
      end
   end

   assign rxFullEff = rxFull_r && !(rdData && armRx_r[5]);
   assign load      = frameEvt && !rxFullEff;
   assign ovrEvt    = frameEvt && rxFullEff;

   // Receive flags: a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxFull_r    <= 1'b0;
         idle_r      <= 1'b0;
         overrun_r   <= 1'b0;
         noise_r     <= 1'b0;
         framing_r   <= 1'b0;
         parity_r    <= 1'b0;
         breakSeen_r <= 1'b0;
      end else begin
         if (rdData) begin
            rxFull_r  <= rxFull_r & ~armRx_r[5]; // [R9]
            idle_r    <= idle_r & ~armRx_r[4]; // [R12]
            overrun_r <= overrun_r & ~armRx_r[3]; // [R14]
            noise_r   <= noise_r & ~armRx_r[2]; // [R15]
            framing_r <= framing_r & ~armRx_r[1]; // [R16]
            parity_r  <= parity_r & ~armRx_r[0]; // [R17]
            if (armBrk_r) begin
               breakSeen_r <= 1'b0; // [R19]
            end
         end
         if (load) begin
            rxFull_r <= 1'b1; // [R8]
            if (noiseSeen_r || noisy) begin
               noise_r <= 1'b1; // [R15]
            end
            if (stopBad) begin
               framing_r <= 1'b1; // [R16]
            end
            if (parBad) begin
               parity_r <= 1'b1; // [R17]
            end
         end
         if (ovrEvt) begin
            overrun_r <= 1'b1; // [R13]
         end
         if (frameEvt && brk) begin
            rxFull_r  <= 1'b1; // [R18]
            framing_r <= 1'b1;
            if (breakArm_r) begin
               breakSeen_r <= 1'b1;
            end
         end
         if (idleHit && idleArm_r) begin
            idle_r <= 1'b1; // [R10]
         end
      end
   end

   // Receive data keeps its contents over reset; overrun leaves it alone
   always_ff @(posedge clk) begin
      if (load) begin
         rxData_r <= rxWord_r[7:0]; // [R13]
         rx9_r    <= (mode9 && !brk) ? rxWord_r[8] : (!mode9 && rxWord_r[7]); // [R18]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idleArm_r  <= 1'b0;
         breakArm_r <= 1'b0;
         rxActive_r <= 1'b0;
         reOld_r    <= 1'b0;
      end else begin
         reOld_r <= re;
         if ((re && !reOld_r) || (rdData && armRx_r[4])) begin
            idleArm_r <= 1'b0; // [R11]
         end
         if (load && !brk) begin
            idleArm_r <= 1'b1; // [R11]
         end
         if (rxdSync_r) begin
            breakArm_r <= 1'b1;
         end else if (frameEvt && brk && breakArm_r) begin
            breakArm_r <= 1'b0; // [R19]
         end
         if (falseEvt || idleHit) begin
            rxActive_r <= 1'b0; // [R20]
         end
         if (startEvt) begin
            rxActive_r <= 1'b1; // [R20]
         end
      end
   end

   // Requests are registered so every output leaves a flip-flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txIrq_r  <= 1'b0;
         rxIrq_r  <= 1'b0;
         errIrq_r <= 1'b0;
      end else begin
         txIrq_r  <= (txEmpty_r && ctrl2_r[C2_TXE_IE]) || (txDone_r && ctrl2_r[C2_TXD_IE]); // [R3] [R7]
         rxIrq_r  <= (rxFull_r && ctrl2_r[C2_RXF_IE]) || (idle_r && ctrl2_r[C2_IDLE_IE]); // [R8] [R10]
         errIrq_r <= (overrun_r && errEn_r[C3E_OVR]) || (noise_r && errEn_r[C3E_NOISE]) ||
                     (framing_r && errEn_r[C3E_FRAME]) || (parity_r && errEn_r[C3E_PAR]); // [R1] [R23]
      end
   end

   assign hreadyout = hreadyout_r;
   assign hresp     = hresp_r;
   assign hrdata    = hrdata_r;
   assign txd       = txd_r;
   assign irqTx     = txIrq_r;
   assign irqRx     = rxIrq_r;
   assign irqErr    = errIrq_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_err_irq_gate: assert property (((noise_r && errEn_r[C3E_NOISE]) || (parity_r && errEn_r[C3E_PAR])) |=> irqErr)
      else $error("error request missing"); // [R1]
   chk_txe_clear_seq: assert property ($fell(txEmpty_r) |-> $past(wrData && armTxe_r)) // [R4]
      else $error("empty flag cleared without sequence");
   chk_txdone_empty: assert property (txDone_r |-> $past(txEmpty_r) && $past(txState_r == TX_IDLE)) // [R5]
      else $error("done flag while sending");
   chk_tx_irq_path: assert property ((txEmpty_r && ctrl2_r[C2_TXE_IE]) |=> irqTx) // [R3]
      else $error("transmit request missing");
   chk_rx_full_load: assert property (load && !brk |=> rxFull_r && (rxData_r == $past(rxWord_r[7:0]))) // [R8]
      else $error("received byte not loaded");
   chk_ovr_keep_data: assert property (ovrEvt |=> overrun_r && $stable(rxData_r)) // [R13]
      else $error("overrun handling wrong");
   chk_ovr_clear_arm: assert property ($fell(overrun_r) |-> $past(rdData && armRx_r[3])) // [R14]
      else $error("overrun cleared without status read");
   chk_break_flags: assert property ((frameEvt && brk && breakArm_r) |=> breakSeen_r && framing_r && rxFull_r) // [R18]
      else $error("break flags not set");
   chk_idle_gate: assert property ($rose(idle_r) |-> $past(idleArm_r) && $past(idleHit)) // [R11]
      else $error("idle set without fresh character");
   chk_start_active: assert property (startEvt |=> rxActive_r [*2]) // [R20]
      else $error("reception active not set");

   cov_overrun: cover property (ovrEvt);
   cov_break: cover property (frameEvt && brk);
   cov_tx_done: cover property ($rose(txDone_r));
   cov_idle: cover property ($rose(idle_r));

endmodule

`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
   import usf_pkg::*;
;
   // Sixteen RT ticks of two clocks each
   localparam int BIT = 32;
   logic        clk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, go = 1'b0, stopV = 1'b1, rdPend = 1'b0;
   logic        hready, hreadyout, hresp, rxd, txd, irqTx, irqRx, irqErr, busy;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0]  dv = 8'h00, b1, b2, b3;
   logic [9:0]  fr = {1'b1, 8'hA5, 1'b0};
   logic [15:0] expQ[$];
   logic [15:0] e;
   int          err_count = 0, n_compared = 0, cyc = 0;
   integer      seed = 32'h9BBC63F0;
   assign hready = hreadyout;
   usf_uart_flags #(.RT_DIV(2)) dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rxd(rxd), .txd(txd), .irqTx(irqTx), .irqRx(irqRx), .irqErr(irqErr));
   usf_remote_tx #(.BIT_CLKS(BIT)) far (.clk(clk), .go(go), .dat(dv), .stopVal(stopV), .busy(busy), .rxd(rxd));
   initial forever #20 clk = ~clk;
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
      haddr  <= {24'h0, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      rdPend <= !wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rdPend <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] ev, input logic [7:0] m = 8'hFF);
      expQ.push_back({m, ev});
      bus(idx, 1'b0, 8'h00);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
      bus(idx, 1'b1, wd);
   endtask
   task automatic chk(input string nm, input logic ev, input logic got);
      n_compared++;
      if (got !== ev) begin
         err_count++;
         $display("mismatch %s expected %b seen %b", nm, ev, got);
      end
   endtask
   task automatic send(input logic [7:0] d, input logic s);
      dv    <= d;
      stopV <= s;
      go    <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   // Read data is judged in its data phase, against the oldest note
   always @(posedge clk) begin
      if (rdPend && hready) begin
         e = expQ.pop_front();
         n_compared++;
         if ((hrdata & {24'hFFFFFF, e[15:8]}) !== {24'h0, e[7:0]}) begin
            err_count++;
            $display("mismatch hrdata expected %h seen %h", e[7:0], hrdata[7:0]);
         end
         n_compared++;
         if (hresp !== HRESP_OKAY) begin
            err_count++;
            $display("mismatch hresp expected %b seen %b", HRESP_OKAY, hresp);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(IDX_FLAGS1, 8'hC0);
      rd(IDX_FLAGS2, 8'h00);
      rd(IDX_CTRL3, 8'h00, 8'h4F);
      rd(6'h3F, 8'h00);
      chk("irqErr", 1'b0, irqErr);
      for (int k = 0; k < 3; k++) begin
         wr(IDX_CTRL2, 8'h80 >> k);
         repeat (2) @(posedge clk);
         chk("irqTx", k < 2, irqTx);
      end
      wr(IDX_CTRL3, 8'h0F);
      wr(IDX_CTRL2, 8'h24);
      repeat (12 * BIT) @(posedge clk);
      rd(IDX_FLAGS1, 8'hC0);
      b1 = 8'($random(seed));
      send(b1, 1'b1);
      rd(IDX_FLAGS1, 8'hE0);
      chk("irqRx", 1'b1, irqRx);
      repeat (12 * BIT) @(posedge clk);
      rd(IDX_FLAGS1, 8'hF0);
      rd(IDX_DATA, b1);
      rd(IDX_FLAGS1, 8'hC0);
      b2 = 8'($random(seed));
      b3 = ~b2;
      send(b2, 1'b1);
      send(b3, 1'b1);
      rd(IDX_FLAGS1, 8'hE8);
      chk("irqErr", 1'b1, irqErr);
      rd(IDX_DATA, b2);
      rd(IDX_FLAGS1, 8'hC0);
      send(b3, 1'b1);
      rd(IDX_FLAGS1, 8'hE0);
      send(b2, 1'b1);
      rd(IDX_DATA, b3);
      rd(IDX_FLAGS1, 8'hC8);
      rd(IDX_DATA, b3);
      rd(IDX_FLAGS1, 8'hC0);
      for (int k = 0; k < 3; k++) begin
         // Middle pass is nine-bit with parity: far stop slot is the ninth bit
         wr(IDX_CTRL1, {6'h0, k == 1, k == 1});
         send(k == 2 ? 8'h00 : 8'h01, 1'b0);
         repeat (BIT) @(posedge clk);
         rd(IDX_FLAGS1, k == 1 ? 8'hE1 : 8'hE2);
         chk("irqErr", 1'b1, irqErr);
         rd(IDX_FLAGS2, {6'h0, k == 2, 1'b0}, 8'h02);
         rd(IDX_DATA, {7'h0, k != 2});
         rd(IDX_FLAGS1, 8'hC0);
      end
      rd(IDX_FLAGS2, 8'h00, 8'h02);
      chk("irqErr", 1'b0, irqErr);
      rd(IDX_DATA, 8'h00);
      rd(IDX_FLAGS1, 8'hC0, 8'hC0);
      wr(IDX_DATA, 8'hA5);
      rd(IDX_FLAGS1, 8'h00, 8'hC0);
      wr(IDX_CTRL2, 8'h08);
      repeat (40 * BIT) if (txd === 1'b1) @(posedge clk);
      repeat (BIT / 2) @(posedge clk);
      for (int k = 0; k < 10; k++) begin
         chk("txd", fr[k], txd);
         repeat (BIT) @(posedge clk);
      end
      repeat (BIT) @(posedge clk);
      // Last status read saw the flag clear, so this write must not clear it
      wr(IDX_DATA, 8'h3C);
      rd(IDX_FLAGS1, 8'hC0, 8'hC0);
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ---- verification/usf_remote_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
module usf_remote_tx #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] dat,
   input  wire logic       stopVal,
   output var  logic       busy,
   output var  logic       rxd
);
   logic [9:0] frame_r;
   initial begin
      busy = 1'b0;
      rxd  = 1'b1;
      forever begin
         @(posedge clk);
         if (go) begin
            frame_r = {stopVal, dat, 1'b0};
            busy <= 1'b1;
            for (int i = 0; i < 10; i++) begin
               rxd <= frame_r[i];
               repeat (BIT_CLKS) @(posedge clk);
            end
            // Line has a pull-up, so it rests high
            rxd  <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
